/* common/shx_pkg.sv */
package shx_pkg;

  // Characters of the command line.
  localparam logic [7:0] CHAR_CR      = 8'h0d;
  localparam logic [7:0] CHAR_SPACE   = 8'h20;
  localparam logic [7:0] CHAR_COMMA   = 8'h2c;
  localparam logic [7:0] CHAR_QUERY   = 8'h3f;
  localparam logic [7:0] CHAR_LOAD    = 8'h4c;
  localparam logic [7:0] CHAR_SEND    = 8'h53;
  localparam logic [7:0] CHAR_FMT_A   = 8'h49;
  localparam logic [7:0] CHAR_FMT_B   = 8'h4d;
  localparam logic [7:0] CHAR_FMT_C   = 8'h54;

  // Answer codes; zero means the command completed.
  localparam logic [7:0] CODE_OK      = 8'h00;
  localparam logic [7:0] CODE_ORDER   = 8'h0a;
  localparam logic [7:0] CODE_SIZE    = 8'h0c;
  localparam logic [7:0] CODE_ILLEGAL = 8'h0e;
  localparam logic [7:0] CODE_SYNTAX  = 8'h10;

  // Argument width and the default span of an abbreviated send.
  localparam int          ARG_W        = 24;
  localparam logic [23:0] DEFAULT_SPAN = 24'h00_00ff;

  // Help listing: item count and the documented argument ranges.
  localparam logic [3:0]  HELP_ITEMS    = 4'hb;
  localparam logic [19:0] HELP_ADDR_MAX = 20'h7_ffff;
  localparam logic [7:0]  HELP_DATA_MAX = 8'hff;

  // Default buffer address width, 512 KiB.
  localparam int BUF_ADDR_W = 19;

  typedef enum logic [1:0] {
    FMT_A,
    FMT_B,
    FMT_C
  } shx_fmt_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
    logic        last;
  } shx_link_word_type;

  typedef struct packed {
    logic [3:0]  item;
    logic [19:0] addr_max;
    logic [7:0]  data_max;
    logic        last;
  } shx_help_type;

endpackage : shx_pkg

/* src/shx_cmd.sv */
// Summary of operation
// - Load commands with any argument answer code 16 and start nothing.
// - Load receives record data from the link into buffer memory.
// - Send transmits the inclusive buffer range in the chosen format.
// - Send with start above end aborts with code 10.
// - Send with end beyond the buffer aborts with code 12.
// - A non-hex character in an address aborts with code 14.
// - Omitted start is 0; missing end defaults per comma and start.
// - Transfers use only the simple handshake link to an emulator.
// - Help lists the eleven commands with address and data ranges.
`timescale 1ns/100ps
module shx_cmd #(
  parameter int ADDR_W = shx_pkg::BUF_ADDR_W  // Buffer address width
) (
  input  wire logic                       clk,         // 50 MHz clock
  input  wire logic                       arst_n,      // Async reset
  input  wire logic                       cmd_valid,   // Console char
  input  wire logic [7:0]                 cmd_char,    // ASCII code
  output var  logic                       cmd_ready,   // Char taken
  output var  logic                       prompt,      // Idle prompt
  output var  logic                       resp_valid,  // Answer pulse
  output var  logic [7:0]                 resp_code,   // 0 or error
  output var  logic                       help_valid,  // Help item
  output var  shx_pkg::shx_help_type      help_item,   // Help content
  output var  shx_pkg::shx_fmt_type       link_fmt,    // Record format
  input  wire logic                       rx_valid,    // Record byte
  input  wire shx_pkg::shx_link_word_type rx_word,     // Addr and data
  input  wire logic                       rx_abort,    // Link lost
  output var  logic                       rx_ready,    // Load active
  output var  logic                       tx_valid,    // Byte offered
  output var  shx_pkg::shx_link_word_type tx_word,     // Addr and data
  input  wire logic                       tx_ready     // Byte accepted
);

  localparam int ARG_W_L = shx_pkg::ARG_W;
  localparam logic [ARG_W_L-1:0] CAPACITY = ARG_W_L'(1 << ADDR_W);

  typedef enum logic [1:0] {
    K_NONE,
    K_LOAD,
    K_SEND,
    K_HELP
  } shx_kind_type;

  typedef enum logic [3:0] {
    S_IDLE,
    S_CMD2,
    S_ARGS,
    S_CHECK,
    S_LOAD,
    S_SEND_RD,
    S_SEND_TX,
    S_HELP,
    S_DONE
  } shx_state_type;

  shx_state_type        state;
  shx_state_type        next_state;
  shx_kind_type         kind;
  logic                 cmd_bad;
  logic                 arg_seen;
  logic                 comma_seen;
  logic                 syntax_bad;
  logic                 illegal;
  logic                 ovf;
  logic [ARG_W_L-1:0]   start_acc;
  logic [ARG_W_L-1:0]   end_acc;
  logic [ARG_W_L-1:0]   addr;
  logic [ARG_W_L-1:0]   end_addr;
  logic [7:0]           mem [0:(1 << ADDR_W)-1];
  logic [7:0]           rd_data;
  logic [3:0]           help_cnt;

  wire logic [3:0] nibble;
  wire logic       is_hex;

  shx_hex_digit u_digit (
    .char_in (cmd_char),
    .nibble  (nibble),
    .is_hex  (is_hex)
  );

  // Decoding of the incoming character.
  wire logic take      = cmd_valid & cmd_ready;
  wire logic is_cr     = (cmd_char == shx_pkg::CHAR_CR);
  wire logic is_space  = (cmd_char == shx_pkg::CHAR_SPACE);
  wire logic is_comma  = (cmd_char == shx_pkg::CHAR_COMMA);
  wire logic fmt_ok    = (cmd_char == shx_pkg::CHAR_FMT_A) |
                         (cmd_char == shx_pkg::CHAR_FMT_B) |
                         (cmd_char == shx_pkg::CHAR_FMT_C);
  wire shx_pkg::shx_fmt_type fmt_sel =
    (cmd_char == shx_pkg::CHAR_FMT_B) ? shx_pkg::FMT_B :
    (cmd_char == shx_pkg::CHAR_FMT_C) ? shx_pkg::FMT_C : shx_pkg::FMT_A;
  wire logic cmd2_ok   = (kind == K_HELP) ? (cmd_char == shx_pkg::CHAR_QUERY)
                                          : fmt_ok;

  // A digit that pushes a nonzero nibble off the top can only be too large.
  wire logic [ARG_W_L-1:0] digit_acc_s = {start_acc[ARG_W_L-5:0], nibble};
  wire logic [ARG_W_L-1:0] digit_acc_e = {end_acc[ARG_W_L-5:0], nibble};
  wire logic               top_s       = |start_acc[ARG_W_L-1:ARG_W_L-4];
  wire logic               top_e       = |end_acc[ARG_W_L-1:ARG_W_L-4];

  // Defaults: start is zero unless typed; end follows the comma form.
  wire logic [ARG_W_L-1:0] res_start = start_acc;
  wire logic [ARG_W_L:0]   span_sum  = {1'b0, start_acc} +
                                       {1'b0, shx_pkg::DEFAULT_SPAN};
  wire logic [ARG_W_L-1:0] res_end   = comma_seen ? end_acc
                                       : span_sum[ARG_W_L-1:0];
  wire logic               end_ovf   = ~comma_seen & span_sum[ARG_W_L];

  // Checks in priority order; syntax first, then characters, then range.
  wire logic err_syntax = cmd_bad | syntax_bad |
                          ((kind != K_SEND) & arg_seen);
  wire logic err_char   = illegal;
  // Range checks belong to send only; load and help carry no range.
  wire logic is_send    = (kind == K_SEND);
  wire logic err_order  = is_send & (res_start > res_end);
  wire logic err_size   = is_send &
                          (ovf | end_ovf | (res_end >= CAPACITY));
  wire logic [7:0] check_code =
    err_syntax ? shx_pkg::CODE_SYNTAX  :
    err_char   ? shx_pkg::CODE_ILLEGAL :
    err_order  ? shx_pkg::CODE_ORDER   :
    err_size   ? shx_pkg::CODE_SIZE    : shx_pkg::CODE_OK;
  wire logic check_fail = (check_code != shx_pkg::CODE_OK);

  wire logic rx_end   = rx_abort | (rx_valid & rx_word.last);
  wire logic at_end   = (addr == end_addr);
  wire logic help_end = (help_cnt == shx_pkg::HELP_ITEMS);

  // The read follows the coming address, so the byte of a word is in
  // rd_data when the word is built; reading addr itself lags by one.
  wire logic [ARG_W_L-1:0] next_addr =
    (state == S_CHECK) ? res_start :
    (state == S_SEND_TX && tx_ready && !at_end) ? addr + 1'b1 : addr;

  // Sequencing of one command line.
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE:    if (take && !is_cr && !is_space) next_state = S_CMD2;
      S_CMD2:    if (take) next_state = is_cr ? S_CHECK : S_ARGS;
      S_ARGS:    if (take && is_cr) next_state = S_CHECK;
      S_CHECK: begin
        if (check_fail)            next_state = S_DONE;
        else if (kind == K_LOAD)   next_state = S_LOAD;
        else if (kind == K_SEND)   next_state = S_SEND_RD;
        else                       next_state = S_HELP;
      end
      S_LOAD:    if (rx_end) next_state = S_DONE;
      S_SEND_RD: next_state = S_SEND_TX;
      S_SEND_TX: if (tx_ready) next_state = at_end ? S_DONE : S_SEND_RD;
      S_HELP:    if (help_end) next_state = S_DONE;
      S_DONE:    next_state = S_IDLE;
      default:   next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Handshake outputs are registered from the coming state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ready <= 1'b0;
      prompt    <= 1'b0;
      rx_ready  <= 1'b0;
    end else begin
      cmd_ready <= (next_state == S_IDLE) | (next_state == S_CMD2) |
                   (next_state == S_ARGS);
      prompt    <= (next_state == S_IDLE);
      rx_ready  <= (next_state == S_LOAD);
    end
  end

  // First character names the family, second the record format.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kind     <= K_NONE;
      cmd_bad  <= 1'b0;
      link_fmt <= shx_pkg::FMT_A;
    end else if (state == S_IDLE && take) begin
      kind    <= (cmd_char == shx_pkg::CHAR_LOAD)  ? K_LOAD :
                 (cmd_char == shx_pkg::CHAR_SEND)  ? K_SEND :
                 (cmd_char == shx_pkg::CHAR_QUERY) ? K_HELP : K_NONE;
      cmd_bad <= 1'b0;
    end else if (state == S_CMD2 && take) begin
      cmd_bad  <= (kind == K_NONE) | is_cr | ~cmd2_ok;
      link_fmt <= fmt_sel;
    end
  end

  // Argument collection; everything clears when a new line begins.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arg_seen   <= 1'b0;
      comma_seen <= 1'b0;
      syntax_bad <= 1'b0;
      illegal    <= 1'b0;
      ovf        <= 1'b0;
      start_acc  <= '0;
      end_acc    <= '0;
    end else if (state == S_IDLE) begin
      arg_seen   <= 1'b0;
      comma_seen <= 1'b0;
      syntax_bad <= 1'b0;
      illegal    <= 1'b0;
      ovf        <= 1'b0;
      start_acc  <= '0;
      end_acc    <= '0;
    end else if (state == S_ARGS && take && !is_cr && !is_space) begin
      arg_seen <= 1'b1;
      if (is_comma) begin
        syntax_bad <= comma_seen;
        comma_seen <= 1'b1;
      end else if (!is_hex) begin
        illegal <= 1'b1;
      end else if (comma_seen) begin
        end_acc <= digit_acc_e;
        ovf     <= ovf | top_e;
      end else begin
        start_acc <= digit_acc_s;
        ovf       <= ovf | top_s;
      end
    end
  end

  // The buffer itself; load writes bytes that fall inside it.
  always_ff @(posedge clk) begin
    if (state == S_LOAD && rx_valid && (rx_word.addr < CAPACITY)) begin
      mem[rx_word.addr[ADDR_W-1:0]] <= rx_word.data;
    end
    rd_data <= mem[next_addr[ADDR_W-1:0]];
  end

  // Send walks from start to end, one byte per link handshake.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr     <= '0;
      end_addr <= '0;
      tx_valid <= 1'b0;
      tx_word  <= '0;
    end else begin
      addr <= next_addr;
      if (state == S_CHECK) begin
        end_addr <= res_end;
      end
      if (state == S_SEND_RD) begin
        tx_valid      <= 1'b1;
        tx_word.addr  <= addr;
        tx_word.data  <= rd_data;
        tx_word.last  <= at_end;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // Help items run one per cycle; the console side is never slower.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      help_cnt   <= '0;
      help_valid <= 1'b0;
      help_item  <= '0;
    end else begin
      help_cnt   <= (state == S_HELP) ? help_cnt + 1'b1 : 4'h1;
      help_valid <= (state == S_HELP);
      help_item.item     <= help_cnt;
      help_item.addr_max <= shx_pkg::HELP_ADDR_MAX;
      help_item.data_max <= shx_pkg::HELP_DATA_MAX;
      help_item.last     <= help_end;
    end
  end

  // One answer per command line, ok or the first failing check.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid <= 1'b0;
      resp_code  <= shx_pkg::CODE_OK;
    end else begin
      resp_valid <= (next_state == S_DONE) && (state != S_DONE);
      if (state == S_CHECK) begin
        resp_code <= check_code;
      end
    end
  end

endmodule : shx_cmd

/* src/shx_hex_digit.sv */
`timescale 1ns/100ps
module shx_hex_digit (
  input  wire logic [7:0] char_in,  // ASCII character
  output wire logic [3:0] nibble,   // Value of the digit
  output wire logic       is_hex    // Character is 0-9, A-F or a-f
);

  // Upper and lower case letters are both accepted.
  wire logic is_num   = (char_in >= 8'h30) && (char_in <= 8'h39);
  wire logic is_upper = (char_in >= 8'h41) && (char_in <= 8'h46);
  wire logic is_lower = (char_in >= 8'h61) && (char_in <= 8'h66);
  wire logic [7:0] alpha = is_upper ? (char_in - 8'h37) : (char_in - 8'h57);

  assign is_hex = is_num | is_upper | is_lower;
  assign nibble = is_num ? char_in[3:0] : alpha[3:0];

endmodule : shx_hex_digit

/* verification/shx_cmd_assertions.sv */
`timescale 1ns/100ps
module shx_cmd_checker #(
  parameter int ADDR_W = shx_pkg::BUF_ADDR_W  // Buffer address width
) (
  input wire logic                       clk,        // Clock
  input wire logic                       arst_n,     // Reset
  input wire logic                       prompt,     // Idle
  input wire logic                       resp_valid, // Answer
  input wire logic [7:0]                 resp_code,  // Code
  input wire logic                       help_valid, // Help
  input wire shx_pkg::shx_help_type      help_item,  // Item
  input wire logic                       rx_valid,   // Byte
  input wire shx_pkg::shx_link_word_type rx_word,    // Word
  input wire logic                       rx_abort,   // Lost
  input wire logic                       rx_ready,   // Load
  input wire logic                       tx_valid,   // Offer
  input wire shx_pkg::shx_link_word_type tx_word,    // Word
  input wire logic                       tx_ready    // Taken
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Transfer steps as seen on the link.
  sequence s_tx_wait; tx_valid && !tx_ready; endsequence
  sequence s_tx_end; tx_valid && tx_ready && tx_word.last; endsequence
  sequence s_rx_end; rx_ready && rx_valid && rx_word.last; endsequence
  property p_tx_hold; s_tx_wait |=> tx_valid && $stable(tx_word);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("send word changed while waiting");
  property p_tx_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
  a_tx_gap: assert property (p_tx_gap)
    else $error("no read cycle between words");
  property p_tx_done;
    s_tx_end |-> ##[1:4] resp_valid && resp_code == shx_pkg::CODE_OK;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("send end not answered");
  property p_tx_range; tx_valid |-> (tx_word.addr >> ADDR_W) == 0;
  endproperty
  a_tx_range: assert property (p_tx_range)
    else $error("send address beyond buffer");
  property p_load_end;
    s_rx_end |=> resp_valid && resp_code == shx_pkg::CODE_OK;
  endproperty
  a_load_end: assert property (p_load_end)
    else $error("load end not answered");
  property p_abort; rx_ready && rx_abort |=> resp_valid; endproperty
  a_abort: assert property (p_abort)
    else $error("link loss not answered");
  property p_pulse; resp_valid |=> !resp_valid; endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer longer than one cycle");
  property p_idle; prompt |-> !tx_valid && !rx_ready; endproperty
  a_idle: assert property (p_idle)
    else $error("transfer active at prompt");
  property p_help;
    help_valid |-> help_item.addr_max == 20'h7_ffff
      && help_item.data_max == 8'hff;
  endproperty
  a_help: assert property (p_help)
    else $error("help range wrong");
endmodule : shx_cmd_checker

/* verification/shx_emu_model.sv */
`timescale 1ns/100ps
module shx_emu_model (
  input  wire logic                       clk,       // Clock
  input  wire logic                       slow,      // Stall mode
  input  wire logic [8:0]                 n_load,    // Load length
  input  wire logic                       abort_now, // Drop link
  input  wire logic                       rx_ready,  // Load active
  output var  logic                       rx_valid,  // Byte offered
  output var  shx_pkg::shx_link_word_type rx_word,   // Load word
  output var  logic                       rx_abort,  // Link lost
  input  wire logic                       tx_valid,  // Word offered
  input  wire shx_pkg::shx_link_word_type tx_word,   // Send word
  output var  logic                       tx_ready   // Word taken
);
  shx_pkg::shx_link_word_type got[$];
  int k = 0;
  int ph = 0;
  // Samples at the edge and answers just after it; an idle word line
  // flips every cycle so a stale value is never mistaken for data.
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_word);
    if (rx_valid && rx_ready === 1'b1) k++;
    ph = (ph + 1) % 3;
    #1;
    if (rx_ready !== 1'b1) k = 0;
    rx_valid = rx_ready === 1'b1 && k < n_load;
    rx_word = rx_valid ? {24'(k), 8'(k) ^ 8'h5a, k == n_load - 1}
                       : ~rx_word;
    rx_abort = abort_now && rx_ready === 1'b1;
    tx_ready = tx_valid === 1'b1 && !(slow && ph == 0);
  end
  initial rx_word = '0;
endmodule : shx_emu_model

/* verification/tb_shx_cmd.sv */
`timescale 1ns/100ps
module tb_shx_cmd;
  localparam int AW = 8;  // Small buffer keeps full sends short.
  logic clk, arst_n, cmd_valid, cmd_ready, prompt, resp_valid;
  logic help_valid, rx_valid, rx_abort, rx_ready, tx_valid, tx_ready;
  logic slow, abort_now, saw_rx;
  logic [7:0] cmd_char, resp_code;
  logic [8:0] n_load;
  shx_pkg::shx_help_type help_item;
  shx_pkg::shx_fmt_type link_fmt;
  shx_pkg::shx_link_word_type rx_word, tx_word;
  int n_errors = 0, tests_run = 0, cyc = 0, n_help = 0;
  shx_cmd #(.ADDR_W(AW)) dut (.clk(clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_char(cmd_char), .cmd_ready(cmd_ready),
    .prompt(prompt), .resp_valid(resp_valid), .resp_code(resp_code),
    .help_valid(help_valid), .help_item(help_item), .link_fmt(link_fmt),
    .rx_valid(rx_valid), .rx_word(rx_word), .rx_abort(rx_abort),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_word(tx_word),
    .tx_ready(tx_ready));
  shx_emu_model emu (.clk(clk), .slow(slow), .n_load(n_load),
    .abort_now(abort_now), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_abort(rx_abort), .tx_valid(tx_valid),
    .tx_word(tx_word), .tx_ready(tx_ready));
  // Clock, hang guard and help and load observers.
  always #10 clk = ~clk;
  always @(negedge clk) begin
    cyc++;
    if (help_valid === 1'b1) begin
      n_help++;
      chk(help_item.item, n_help);
      chk(help_item.last, n_help == 11);
    end
    if (rx_ready === 1'b1) saw_rx = 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Offers one character and holds it until the design takes it.
  task automatic put(input logic [7:0] c);
    int i;
    cmd_char = c;
    cmd_valid = 1'b1;
    for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    #1;
  endtask : put
  task automatic line(input string s);
    foreach (s[i]) put(s[i]);
    put(shx_pkg::CHAR_CR);
    cmd_valid = 1'b0;
  endtask : line
  // Errors answer at once, transfers only after the last word.
  task automatic cmd(input string s, input logic [7:0] code,
                     input int first, input int cnt);
    int i;
    emu.got.delete();
    line(s);
    for (i = 0; i < (code ? 4 : 3000) && resp_valid !== 1'b1; i++)
      @(negedge clk);
    chk(resp_valid, 1'b1);
    chk(resp_code, code);
    for (i = 0; i < 3 && prompt !== 1'b1; i++) @(negedge clk);
    chk(prompt, 1'b1);
    chk(emu.got.size(), cnt);
    foreach (emu.got[j]) begin
      chk(emu.got[j].addr, first + j);
      chk(emu.got[j].data, 8'(first + j) ^ 8'h5a);
      chk(emu.got[j].last, j == cnt - 1);
    end
    @(posedge clk);
    #1;
  endtask : cmd
  task automatic t_load();
    string s[3] = '{"LI", "LM", "LT"};
    foreach (s[i]) begin
      cmd(s[i], 8'h00, 0, 0);
      chk(link_fmt, i);
    end
    saw_rx = 1'b0;
    cmd("LI 0,1FFF", 8'h10, 0, 0);
    chk(saw_rx, 1'b0);
  endtask : t_load
  task automatic t_abort();
    fork
      cmd("LM", 8'h00, 0, 0);
      begin
        repeat (12) @(posedge clk);
        #1 abort_now = 1'b1;
      end
    join
    abort_now = 1'b0;
  endtask : t_abort
  task automatic t_send();
    slow = 1'b1;
    cmd("SM 7E,81", 8'h00, 126, 4);
    chk(link_fmt, 1);
    cmd("ST fe,FF", 8'h00, 254, 2);
    slow = 1'b0;
  endtask : t_send
  task automatic t_defaults();
    cmd("SI", 8'h00, 0, 256);
    cmd("SM,", 8'h00, 0, 1);
    cmd("ST ,2", 8'h00, 0, 3);
    cmd("SI 20,", 8'h0a, 0, 0);
    cmd("SM 20", 8'h0c, 0, 0);
  endtask : t_defaults
  task automatic t_errors();
    cmd("SI 100,0", 8'h0a, 0, 0);
    cmd("SI 0,100", 8'h0c, 0, 0);
    cmd("SI 0,G", 8'h0e, 0, 0);
    cmd("SI 0,1234567", 8'h0c, 0, 0);
    cmd("SI 1,2,3", 8'h10, 0, 0);
    n_help = 0;
    cmd("??", 8'h00, 0, 0);
    chk(n_help, 11);
  endtask : t_errors
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_char = 8'h00;
    {slow, abort_now, saw_rx} = 3'b000;
    n_load = 9'h100;
    repeat (20) @(posedge clk);
    chk(prompt, 1'b0);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_load();
    t_send();
    t_defaults();
    t_errors();
    t_abort();
    wrap_up();
  end
endmodule : tb_shx_cmd
bind shx_cmd shx_cmd_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk),
  .arst_n(arst_n), .prompt(prompt), .resp_valid(resp_valid),
  .resp_code(resp_code), .help_valid(help_valid),
  .help_item(help_item), .rx_valid(rx_valid), .rx_word(rx_word),
  .rx_abort(rx_abort), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_word(tx_word), .tx_ready(tx_ready));
